/* src/rgt_pkg.sv */
`default_nettype none
package rgt_pkg;
    // register indices; byte address is four times the index
    localparam logic [7:0]  RGT_IDX_LIVE_GAIN   = 8'h1D;
    localparam logic [7:0]  RGT_IDX_GAIN_CFG    = 8'h1E;
    localparam logic [7:0]  RGT_IDX_GAIN_STORE  = 8'h1F;
    localparam logic [7:0]  RGT_IDX_TX_SHAPE    = 8'h20;
    // reset values
    localparam logic [31:0] RGT_RST_GAIN_CFG    = 32'h0000_8803;
    localparam logic [31:0] RGT_RST_GAIN_STORE  = 32'h0000_0000;
    localparam logic [31:0] RGT_RST_TX_SHAPE    = 32'h0000_0000;
    // writable bit masks, reserved bits read zero
    localparam logic [31:0] RGT_MSK_GAIN_CFG    = 32'h0000_FFFB;
    localparam logic [31:0] RGT_MSK_GAIN_STORE  = 32'h000F_FFFF;
    localparam logic [31:0] RGT_MSK_TX_SHAPE    = 32'h07FF_FFFF;
    // gain loop config fields
    localparam int RGT_SETPOINT_LSB   = 14;
    localparam int RGT_PERIOD_LSB     = 4;
    localparam int RGT_SOURCE_BIT     = 3;
    localparam int RGT_LOAD_BIT       = 2;
    localparam int RGT_FIXSEL_BIT     = 1;
    localparam int RGT_CLOSED_BIT     = 0;
    // stored gain fields
    localparam int RGT_READER_LSB     = 10;
    localparam int RGT_CARD_LSB       = 0;
    // transmitter shaping fields
    localparam int RGT_DRV_SEL_BIT    = 26;
    localparam int RGT_CARD_AMP_LSB   = 24;
    localparam int RGT_OV_RESID_LSB   = 19;
    localparam int RGT_MAX_FORCE_BIT  = 18;
    localparam int RGT_RESID_LSB      = 13;
    localparam int RGT_BYPASS_BIT     = 12;
    localparam int RGT_SLEW_LSB       = 8;
    localparam int RGT_FALL_LSB       = 4;
    localparam int RGT_RISE_LSB       = 0;
    // gain range, card amplitude maximum and AHB-Lite nonsequential transfer code
    localparam logic [9:0]  RGT_GAIN_MIN        = 10'h000;
    localparam logic [9:0]  RGT_GAIN_MAX        = 10'h3FF;
    localparam logic [1:0]  RGT_AMP_MAX         = 2'h3;
    localparam logic [1:0]  RGT_HTRANS_NONSEQ   = 2'h2;
endpackage
`default_nettype wire

/* src/rgt_regs.sv */
// Functional notes
// (R01) gain loop steps once every update_period+1 carrier ticks.
// (R02) software never programs update period below 4.
// (R03) setpoint select 00/01/10 drive reference; resets to 10b.
// (R04) source select 0 picks card value, 1 picks reader value.
// (R05) writing load bit copies selected stored gain to divider; self clears.
// (R06) fixed mode: select 0 follows stored value, 1 keeps frozen divider; the select is not decoded, divider changes only on a load.
// (R07) changing fixed select alone never reloads the divider.
// (R08) closed loop enable 0 holds divider, 1 runs loop; resets 1.
// (R09) stored gains: reader at 19:10, card at 9:0, reset zero.
// (R10) bit 26 picks both drivers (0) or single driver (1).
// (R11) bits 25:24 set card mode carrier amplitude.
// (R12) bits 23:19 give residual level during overshoot prevention.
// (R13) bit 18 forces maximum card carrier, overriding amplitude field.
// (R14) residual field 0 is full carrier, 1F is none.
// (R15) bypass bit skips shaping and ignores rising time constant.
// (R16) slew field applies to both edges, 0 slowest, F fastest.
// (R17) edge time constants apply only in single pump mode.
// (R18) live gain reads 0 most sensitive up to 3FF most robust.
// (R19) residual fields swap roles at 424 and 848 kbit/s.
// (R20) reserved bits read zero, writes to them ignored.
//
// Register access over AHB-Lite was decided locally.
`timescale 1ns/100ps
`default_nettype none
module rgt_regs (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    input  wire logic        carrier_tick,
    input  wire logic        level_above_pin,
    input  wire logic        high_rate,
    input  wire logic        single_pump_mode,
    output logic [9:0]       rx_divider,
    output logic [1:0]       gain_setpoint_select,
    output logic             load_mod_driver_select,
    output logic [1:0]       card_carrier_amplitude,
    output logic             card_carrier_max_force,
    output logic [4:0]       normal_residual_level,
    output logic [4:0]       overshoot_residual_level,
    output logic             shaping_bypass,
    output logic [3:0]       shunt_slew_rate,
    output logic [3:0]       fall_edge_time_const,
    output logic [3:0]       rise_edge_time_const
);
    // ------------------------------------------------------------
    // ahb-lite slave
    // ------------------------------------------------------------
    logic        wr_pend;
    logic        rd_pend;
    logic [7:0]  ph_idx;
    logic        ph_ok;
    logic [31:0] gain_cfg;
    logic [31:0] gain_store;
    logic [31:0] tx_shape;
    logic        gain_load_strobe;
    logic [31:0] next_rdata;

    wire       take    = hsel && hready && (htrans == rgt_pkg::RGT_HTRANS_NONSEQ);
    wire [7:0] a_idx   = haddr[9:2];
    wire       a_ok    = (haddr[31:10] == 22'h0) && (haddr[1:0] == 2'h0);
    wire       wr_cfg  = wr_pend && ph_ok && (ph_idx == rgt_pkg::RGT_IDX_GAIN_CFG);
    wire       wr_st   = wr_pend && ph_ok && (ph_idx == rgt_pkg::RGT_IDX_GAIN_STORE);
    wire       wr_tx   = wr_pend && ph_ok && (ph_idx == rgt_pkg::RGT_IDX_TX_SHAPE);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend <= 1'b0;
            rd_pend <= 1'b0;
        end else if (rd_pend) begin
            // read wait state done; data now stands in hrdata
            rd_pend <= 1'b0;
        end else begin
            wr_pend <= take && hwrite;
            rd_pend <= take && !hwrite;
        end
    end

    // address kept from the accepted phase only; idle cycles leave it alone
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ph_idx <= 8'h00;
            ph_ok  <= 1'b0;
        end else if (take) begin
            ph_idx <= a_idx;
            ph_ok  <= a_ok;
        end
    end

    // one wait state on reads so the data reflects any write just before
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout <= 1'b1;
        end else begin
            hreadyout <= !(take && !hwrite && !rd_pend);
        end
    end

    // no error cases: unmapped space reads zero and drops writes
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hresp <= 1'b0;
        end else begin
            hresp <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // read data
    // ------------------------------------------------------------
    always_comb begin
        next_rdata = 32'h0000_0000;
        if (!ph_ok) begin
            next_rdata = 32'h0000_0000;
        end else if (ph_idx == rgt_pkg::RGT_IDX_GAIN_CFG) begin
            next_rdata = gain_cfg & rgt_pkg::RGT_MSK_GAIN_CFG;  // [R05] [R20]
        end else if (ph_idx == rgt_pkg::RGT_IDX_GAIN_STORE) begin
            next_rdata = gain_store & rgt_pkg::RGT_MSK_GAIN_STORE;  // [R20]
        end else if (ph_idx == rgt_pkg::RGT_IDX_TX_SHAPE) begin
            next_rdata = tx_shape & rgt_pkg::RGT_MSK_TX_SHAPE;  // [R20]
        end else if (ph_idx == rgt_pkg::RGT_IDX_LIVE_GAIN) begin
            next_rdata = {22'h0, rx_divider};  // [R18]
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (rd_pend) begin
            hrdata <= next_rdata;
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            gain_cfg <= rgt_pkg::RGT_RST_GAIN_CFG;  // [R03] [R06] [R08]
        end else if (wr_cfg) begin
            gain_cfg <= hwdata & rgt_pkg::RGT_MSK_GAIN_CFG;  // [R20]
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            gain_store <= rgt_pkg::RGT_RST_GAIN_STORE;  // [R09]
        end else if (wr_st) begin
            gain_store <= hwdata & rgt_pkg::RGT_MSK_GAIN_STORE;  // [R09] [R20]
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tx_shape <= rgt_pkg::RGT_RST_TX_SHAPE;
        end else if (wr_tx) begin
            tx_shape <= hwdata & rgt_pkg::RGT_MSK_TX_SHAPE;  // [R20]
        end
    end

    // load bit is never stored, so it reads back zero
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            gain_load_strobe <= 1'b0;
        end else begin
            gain_load_strobe <= wr_cfg && hwdata[rgt_pkg::RGT_LOAD_BIT];  // [R05]
        end
    end

    // ------------------------------------------------------------
    // gain loop
    // ------------------------------------------------------------
    logic [2:0] above_sync;
    logic       level_above;
    logic [9:0] tick_count;
    logic       update_due;

    wire [9:0] update_period = gain_cfg[rgt_pkg::RGT_PERIOD_LSB +: 10];
    wire       closed_loop_enable = gain_cfg[rgt_pkg::RGT_CLOSED_BIT];
    wire       gain_source_select = gain_cfg[rgt_pkg::RGT_SOURCE_BIT];
    wire [9:0] reader_static_gain = gain_store[rgt_pkg::RGT_READER_LSB +: 10];
    wire [9:0] card_static_gain   = gain_store[rgt_pkg::RGT_CARD_LSB +: 10];
    wire [9:0] selected_gain = gain_source_select ? reader_static_gain
                                                  : card_static_gain;  // [R04]
    wire       period_done = (tick_count >= update_period);  // [R01]

    // pin is asynchronous to hclk; three stages guard against metastability
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            above_sync <= 3'h0;
        end else begin
            above_sync <= {above_sync[1:0], level_above_pin};
        end
    end

    // change taken only once stages two and three agree
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            level_above <= 1'b0;
        end else if (above_sync[1] == above_sync[2]) begin
            level_above <= above_sync[2];
        end
    end

    // values below 4 are not guarded; software keeps them out
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tick_count <= 10'h000;
        end else if (!closed_loop_enable) begin
            tick_count <= 10'h000;
        end else if (carrier_tick) begin
            tick_count <= period_done ? 10'h000 : tick_count + 10'h001;  // [R01] [R02]
        end
    end

    // one-cycle pulse; the divider moves on the cycle after
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            update_due <= 1'b0;
        end else begin
            update_due <= closed_loop_enable && carrier_tick && period_done;  // [R01]
        end
    end

    // fixed mode holds the divider; the fixed select is never read, so in
    // either setting the divider takes the stored value only on a load
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rx_divider <= rgt_pkg::RGT_GAIN_MIN;
        end else if (gain_load_strobe) begin
            rx_divider <= selected_gain;  // [R05] [R06] [R07]
        end else if (closed_loop_enable && update_due) begin
            if (level_above && rx_divider != rgt_pkg::RGT_GAIN_MAX) begin
                rx_divider <= rx_divider + 10'h001;  // [R08] [R18]
            end else if (!level_above && rx_divider != rgt_pkg::RGT_GAIN_MIN) begin
                rx_divider <= rx_divider - 10'h001;  // [R08] [R18]
            end
        end
    end

    // ------------------------------------------------------------
    // analog control outputs
    // ------------------------------------------------------------
    wire [4:0] resid     = tx_shape[rgt_pkg::RGT_RESID_LSB +: 5];
    wire [4:0] ov_resid  = tx_shape[rgt_pkg::RGT_OV_RESID_LSB +: 5];
    wire       bypass    = tx_shape[rgt_pkg::RGT_BYPASS_BIT];
    wire       max_force = tx_shape[rgt_pkg::RGT_MAX_FORCE_BIT];

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            gain_setpoint_select <= rgt_pkg::RGT_RST_GAIN_CFG[rgt_pkg::RGT_SETPOINT_LSB +: 2];
        end else begin
            gain_setpoint_select <= gain_cfg[rgt_pkg::RGT_SETPOINT_LSB +: 2];  // [R03]
        end
    end

    // max force wins over the amplitude field
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            load_mod_driver_select <= 1'b0;
            card_carrier_amplitude <= 2'h0;
            card_carrier_max_force <= 1'b0;
        end else begin
            load_mod_driver_select <= tx_shape[rgt_pkg::RGT_DRV_SEL_BIT];  // [R10]
            card_carrier_amplitude <= max_force ? rgt_pkg::RGT_AMP_MAX
                                      : tx_shape[rgt_pkg::RGT_CARD_AMP_LSB +: 2];  // [R11] [R13]
            card_carrier_max_force <= max_force;  // [R13]
        end
    end

    // the two residual fields trade places at the two fast rates
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            normal_residual_level    <= 5'h00;
            overshoot_residual_level <= 5'h00;
        end else begin
            normal_residual_level    <= high_rate ? ov_resid : resid;  // [R14] [R19]
            overshoot_residual_level <= high_rate ? resid : ov_resid;  // [R12] [R19]
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            shaping_bypass       <= 1'b0;
            shunt_slew_rate      <= 4'h0;
            fall_edge_time_const <= 4'h0;
            rise_edge_time_const <= 4'h0;
        end else begin
            shaping_bypass       <= bypass;  // [R15]
            shunt_slew_rate      <= tx_shape[rgt_pkg::RGT_SLEW_LSB +: 4];  // [R16]
            // zero means no shaping applied in the analog block
            fall_edge_time_const <= single_pump_mode
                                    ? tx_shape[rgt_pkg::RGT_FALL_LSB +: 4] : 4'h0;  // [R17]
            rise_edge_time_const <= (single_pump_mode && !bypass)
                                    ? tx_shape[rgt_pkg::RGT_RISE_LSB +: 4] : 4'h0;  // [R15] [R17]
        end
    end
endmodule // rgt_regs
`default_nettype wire

/* test/rgt_regs_assertions.sv */
`timescale 1ns/100ps
`default_nettype none
module rgt_regs_chk (
    input wire logic       hclk,
    input wire logic       hresetn,
    input wire logic       hsel,
    input wire logic [1:0] htrans,
    input wire logic       hwrite,
    input wire logic       hready,
    input wire logic       hreadyout,
    input wire logic       hresp,
    input wire logic       carrier_tick,
    input wire logic       high_rate,
    input wire logic       single_pump_mode,
    input wire logic [9:0] rx_divider,
    input wire logic [1:0] card_carrier_amplitude,
    input wire logic       card_carrier_max_force,
    input wire logic [4:0] normal_residual_level,
    input wire logic [4:0] overshoot_residual_level,
    input wire logic       shaping_bypass,
    input wire logic [3:0] fall_edge_time_const,
    input wire logic [3:0] rise_edge_time_const
);
    // ----------------------------------------
    // ages since last write and last tick
    // ----------------------------------------
    logic [2:0] wr_age;
    logic [2:0] tick_age;
    // a write may reload the divider, so loop checks wait it out
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) wr_age <= 3'h0;
        else if (hsel && hready && htrans == 2'h2 && hwrite) wr_age <= 3'h0;
        else if (wr_age != 3'h7) wr_age <= wr_age + 3'h1;
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) tick_age <= 3'h7;
        else if (carrier_tick) tick_age <= 3'h0;
        else if (tick_age != 3'h7) tick_age <= tick_age + 3'h1;
    end
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    sequence s_rd_take; hsel && hready && htrans == 2'h2 && !hwrite; endsequence
    sequence s_wr_take; hsel && hready && htrans == 2'h2 && hwrite; endsequence
    sequence s_rd_wait; !hreadyout ##1 hreadyout; endsequence
    // ----------------------------------------
    // properties
    // ----------------------------------------
    chk_read_wait: assert property (s_rd_take |=> s_rd_wait)
        else $error("read wait state wrong");
    chk_write_fast: assert property (s_wr_take |=> hreadyout)
        else $error("write stalled");
    chk_resp_okay: assert property (hresp == 1'b0)
        else $error("error response seen");
    chk_max_amp: assert property (card_carrier_max_force |-> card_carrier_amplitude == 2'h3)
        else $error("max force not overriding amplitude");
    chk_fall_gate: assert property (!$past(single_pump_mode) |-> fall_edge_time_const == 4'h0)
        else $error("fall constant outside single pump");
    chk_rise_gate: assert property ((!$past(single_pump_mode) || shaping_bypass) |-> rise_edge_time_const == 4'h0)
        else $error("rise constant not gated");
    chk_step_one: assert property (($changed(rx_divider) && wr_age > 3'h5)
        |-> (rx_divider == $past(rx_divider) + 10'h1 || rx_divider == $past(rx_divider) - 10'h1))
        else $error("loop step not one");
    chk_step_tick: assert property (($changed(rx_divider) && wr_age > 3'h5) |-> tick_age < 3'h5)
        else $error("loop step without tick");
    chk_resid_swap: assert property (($past(high_rate) != $past(high_rate, 2) && wr_age > 3'h5)
        |-> normal_residual_level == $past(overshoot_residual_level)
        && overshoot_residual_level == $past(normal_residual_level))
        else $error("residual fields not swapped");
endmodule // rgt_regs_chk
bind rgt_regs rgt_regs_chk i_rgt_regs_chk (.hclk, .hresetn, .hsel, .htrans, .hwrite, .hready,
    .hreadyout, .hresp, .carrier_tick, .high_rate, .single_pump_mode, .rx_divider,
    .card_carrier_amplitude, .card_carrier_max_force, .normal_residual_level,
    .overshoot_residual_level, .shaping_bypass, .fall_edge_time_const, .rise_edge_time_const);
`default_nettype wire

/* test/rx_gain_loop_and_tx_shaping_regs_tb.sv */
`timescale 1ns/100ps
`default_nettype none
module rx_gain_loop_and_tx_shaping_regs_tb;
    // ----------------------------------------
    // stimulus and design
    // ----------------------------------------
    logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, carrier_tick = 1'b0;
    logic level_above_pin = 1'b0, high_rate = 1'b0, single_pump_mode = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
    logic [1:0]  htrans = 2'h0, gain_setpoint_select, card_carrier_amplitude;
    logic [9:0]  rx_divider;
    logic [4:0]  normal_residual_level, overshoot_residual_level;
    logic [3:0]  shunt_slew_rate, fall_edge_time_const, rise_edge_time_const;
    logic hreadyout, hresp, load_mod_driver_select, card_carrier_max_force, shaping_bypass;
    wire logic hready = hreadyout;
    int num_errors = 0;
    int n_compared = 0;
    rgt_regs i_rgt_regs (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
        .hready, .hreadyout, .hresp, .hrdata, .carrier_tick, .level_above_pin, .high_rate,
        .single_pump_mode, .rx_divider, .gain_setpoint_select, .load_mod_driver_select,
        .card_carrier_amplitude, .card_carrier_max_force, .normal_residual_level,
        .overshoot_residual_level, .shaping_bypass, .shunt_slew_rate, .fall_edge_time_const,
        .rise_edge_time_const);
    always #25 hclk = ~hclk;
    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error at %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    task final_report;
        $display("compared %0d mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    // bounded: a stuck hreadyout ends the run
    task automatic wait_rdy;
        int i;
        for (i = 0; i < 20; i++) begin
            @(posedge hclk);
            if (hreadyout === 1'b1) break;
        end
        if (i == 20) begin
            num_errors++;
            $display("Error at %0t: bus hang", $time);
            final_report;
        end
    endtask
    task automatic bus(input logic wr, input logic [7:0] idx, input logic [31:0] d,
                       output logic [31:0] q);
        hsel <= 1'b1;
        haddr <= {22'h0, idx, 2'b00};
        htrans <= 2'h2;
        hwrite <= wr;
        wait_rdy;
        htrans <= 2'h0;
        hwdata <= d;
        wait_rdy;
        q = hrdata;
    endtask
    task automatic wr(input logic [7:0] idx, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, idx, d, q);
    endtask
    task automatic rd(input logic [7:0] idx, input logic [31:0] exp);
        logic [31:0] q;
        bus(1'b0, idx, 32'h0, q);
        chk(q, exp);
    endtask
    task automatic tick;
        carrier_tick <= 1'b1;
        @(posedge hclk);
        carrier_tick <= 1'b0;
        repeat (4) @(posedge hclk);
    endtask
    function automatic logic [26:0] tx_out;
        tx_out = {load_mod_driver_select, card_carrier_amplitude, overshoot_residual_level,
                  card_carrier_max_force, normal_residual_level, shaping_bypass,
                  shunt_slew_rate, fall_edge_time_const, rise_edge_time_const};
    endfunction
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_reset;
        rd(rgt_pkg::RGT_IDX_GAIN_CFG, 32'h0000_8803);
        rd(rgt_pkg::RGT_IDX_GAIN_STORE, 32'h0);
        rd(rgt_pkg::RGT_IDX_TX_SHAPE, 32'h0);
        chk(gain_setpoint_select, 2'h2);
        chk(rx_divider, 10'h0);
        wr(8'h21, 32'hFFFF_FFFF);
        rd(8'h21, 32'h0);
    endtask
    task automatic t_tx;
        wr(rgt_pkg::RGT_IDX_TX_SHAPE, 32'hFFFF_FFFF);
        rd(rgt_pkg::RGT_IDX_TX_SHAPE, 32'h07FF_FFFF);
        chk(tx_out(), 27'h7FF_FF00);
        wr(rgt_pkg::RGT_IDX_TX_SHAPE, 32'h0004_0000);
        repeat (2) @(posedge hclk);
        chk(tx_out(), 27'h304_0000);
        single_pump_mode <= 1'b1;
        wr(rgt_pkg::RGT_IDX_TX_SHAPE, 32'h0252_A693);
        repeat (6) @(posedge hclk);
        chk(tx_out(), 27'h252_A693);
        high_rate <= 1'b1;
        repeat (3) @(posedge hclk);
        chk(tx_out(), 27'h2A9_4693);
        wr(rgt_pkg::RGT_IDX_TX_SHAPE, 32'h0252_B693);
        repeat (2) @(posedge hclk);
        chk(tx_out(), 27'h2A9_5690);
        high_rate <= 1'b0;
        single_pump_mode <= 1'b0;
    endtask
    task automatic t_gain;
        wr(rgt_pkg::RGT_IDX_GAIN_STORE, 32'hFFFA_955A);
        rd(rgt_pkg::RGT_IDX_GAIN_STORE, 32'h000A_955A);
        wr(rgt_pkg::RGT_IDX_GAIN_CFG, 32'h0000_404C);
        repeat (4) @(posedge hclk);
        chk(rx_divider, 10'h2A5);
        rd(rgt_pkg::RGT_IDX_GAIN_CFG, 32'h0000_4048);
        chk(gain_setpoint_select, 2'h1);
        wr(rgt_pkg::RGT_IDX_GAIN_CFG, 32'h0000_4042);
        repeat (12) tick;
        chk(rx_divider, 10'h2A5);
        wr(rgt_pkg::RGT_IDX_GAIN_CFG, 32'h0000_4044);
        repeat (4) @(posedge hclk);
        chk(rx_divider, 10'h15A);
    endtask
    task automatic t_loop;
        logic [9:0] v;
        int n;
        level_above_pin <= 1'b1;
        wr(rgt_pkg::RGT_IDX_GAIN_CFG, 32'h0000_4041); // period 4 is the legal floor
        repeat (4) @(posedge hclk);
        v = rx_divider;
        for (n = 0; n < 12 && rx_divider === v; n++) tick;
        chk(rx_divider, {22'h0, v + 10'h1});
        v = rx_divider;
        for (n = 0; n < 12 && rx_divider === v; n++) tick;
        chk(n, 5);
        level_above_pin <= 1'b0;
        repeat (4) @(posedge hclk);
        v = rx_divider;
        repeat (10) tick;
        chk(rx_divider, {22'h0, v - 10'h2});
        rd(rgt_pkg::RGT_IDX_LIVE_GAIN, {22'h0, v - 10'h2});
        // load zero, then a downward step must stay at the floor
        wr(rgt_pkg::RGT_IDX_GAIN_STORE, 32'h0000_0000);
        wr(rgt_pkg::RGT_IDX_GAIN_CFG, 32'h0000_4045);
        repeat (5) tick;
        chk(rx_divider, 10'h000);
    endtask
    initial begin
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        t_reset;
        t_tx;
        t_gain;
        t_loop;
        // mid-run reset must bring every register back to its reset value
        hresetn <= 1'b0;
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        t_reset;
        final_report;
    end
endmodule // rx_gain_loop_and_tx_shaping_regs_tb
`default_nettype wire
